// ===== rtl/sil_status.sv
// Status line and status LED decoding for the supply's user connector
`timescale 1ns/10ps
`default_nettype none
module sil_status #(
  parameter int BLINK_HALF = sil_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_b,
  // Register port
  input  wire logic [sil_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sil_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [sil_pkg::DATA_W-1:0]  o_rdata,
  // Supply state
  input  wire logic                        i_contactor_closed,
  input  wire logic                        i_output_on,
  input  wire logic                        i_at_setpoint,
  input  wire logic                        i_overcurrent,
  input  wire logic                        i_ramping,
  input  wire logic                        i_ramp_paused,
  input  wire logic [sil_pkg::CUR_W-1:0]   i_out_current,
  input  wire logic [sil_pkg::CUR_W-1:0]   i_max_current,
  input  wire logic [1:0]                  i_target_sel,
  input  wire logic [sil_pkg::NUM_TARGETS-1:0] i_life_expired,
  input  wire logic [sil_pkg::NUM_MISC-1:0] i_misc_led_on,
  input  wire logic [sil_pkg::NUM_MISC-1:0] i_misc_led_flash,
  // User connector status lines
  output logic                             o_output_on_n,
  output logic                             o_setpoint_n,
  output logic                             o_arc_n,
  output logic                             o_target_life_expired_n,
  output logic                             o_target_select_code_a,
  output logic                             o_target_select_code_b,
  // Panel indicators and arc handling
  output logic      [sil_pkg::NUM_LEDS-1:0] o_status_led,
  output logic                             o_alarm,
  output logic                             o_arc_shutdown
);
  import sil_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   ctrl;
    logic                arc_seen;
    logic                output_on_n;
    logic                setpoint_n;
    logic                arc_n;
    logic                life_n;
    logic                code_a;
    logic                code_b;
    logic [NUM_LEDS-1:0] led;
    logic                alarm;
    logic                shutdown;
  } sil_state_s;

  sil_state_s          st;
  sil_state_s          next_st;
  logic                blink_tick;
  logic                blink_phase;
  logic                powered;
  logic                discharge_present_led;
  logic                sp_lit;
  logic                sp_flash;
  logic                life_sel;
  logic [CUR_W-1:0]    discharge_present_led_floor;
  logic [NUM_LEDS-1:0] led_on;
  logic [NUM_LEDS-1:0] led_flash;
  logic [NUM_LEDS-1:0] led_mix;
  logic [DATA_W-1:0]   status_word;

  // Single prescaler so every flashing indicator shares one phase
  sil_blink #(
    .HALF_CYC (BLINK_HALF)
  ) u_blink (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .o_blink_tick  (blink_tick),
    .o_blink_phase (blink_phase)
  );

  // Output switched on with the contactor closed
  assign powered = i_contactor_closed & i_output_on;

  // Threshold is max current over 1024; strictly greater than it
  assign discharge_present_led_floor = i_max_current >> DISCHARGE_PRESENT_LED_SHIFT;
  assign discharge_present_led       = i_output_on & (i_out_current > discharge_present_led_floor);

  // Setpoint LED states, both gated by the discharge_present_led indication
  assign sp_lit   = discharge_present_led & i_output_on & i_at_setpoint;
  assign sp_flash = discharge_present_led & i_output_on & ~i_at_setpoint;

  // Unused select code reads as no counter expired
  always_comb begin
    life_sel = 1'b0;
    if (i_target_sel < 2'(NUM_TARGETS)) begin
      life_sel = i_life_expired[i_target_sel];
    end
  end

  // Steady and flashing requests for each status LED
  always_comb begin
    led_on    = '0;
    led_flash = '0;
    led_on[LED_ARC]      = next_st.arc_seen;
    led_on[LED_RAMP]     = i_ramping & ~i_ramp_paused & ~i_at_setpoint;
    led_flash[LED_RAMP]  = i_ramp_paused & ~i_at_setpoint;
    led_on[LED_SETPOINT] = sp_lit;
    led_flash[LED_SETPOINT] = sp_flash;
    led_on[LED_DISCHARGE_PRESENT_LED]   = discharge_present_led;
    led_on[LED_OUTPUT]   = i_output_on;
    led_flash[LED_LIFE]  = life_sel;
    led_on[LED_MISC_LSB +: NUM_MISC]    = i_misc_led_on;
    led_flash[LED_MISC_LSB +: NUM_MISC] = i_misc_led_flash;
  end

  // Mix steady and flash per LED; reduced build drops the auxiliary one
  for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
    if (i == LED_AUX) begin : g_aux
      assign led_mix[i] = ~st.ctrl[CTRL_REDUCED] &
                          (led_on[i] | (led_flash[i] & blink_phase));
    end else begin : g_std
      assign led_mix[i] = led_on[i] | (led_flash[i] & blink_phase);
    end
  end

  // Read-back image of the lines and LEDs
  always_comb begin
    status_word                = '0;
    status_word[ST_OUTPUT_N]   = st.output_on_n;
    status_word[ST_SETPOINT_N] = st.setpoint_n;
    status_word[ST_ARC_N]      = st.arc_n;
    status_word[ST_LIFE_N]     = st.life_n;
    status_word[ST_CODE_A]     = st.code_a;
    status_word[ST_CODE_B]     = st.code_b;
    status_word[ST_ALARM]      = st.alarm;
    status_word[ST_SHUTDOWN]   = st.shutdown;
    status_word[ST_LED_LSB +: NUM_LEDS] = st.led;
  end

  // Next state: register port, arc latch and line drivers
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    if (i_wr && (i_addr == ADDR_CTRL)) begin
      next_st.ctrl = '0;
      next_st.ctrl[CTRL_REDUCED] = i_wdata[CTRL_REDUCED];
      next_st.ctrl[CTRL_MUTE]    = i_wdata[CTRL_MUTE];
    end
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:   next_st.rdata = st.ctrl;
        ADDR_STATUS: next_st.rdata = status_word;
        default:     next_st.rdata = '0;
      endcase
    end
    // Arc stays latched until output goes off; a new trip wins
    if (i_overcurrent) begin
      next_st.arc_seen = 1'b1;
    end else if (!i_output_on) begin
      next_st.arc_seen = 1'b0;
    end
    next_st.shutdown    = next_st.arc_seen;
    // Overbar lines are driven low for true
    next_st.output_on_n = ~powered;
    next_st.setpoint_n  = ~(i_output_on & i_at_setpoint);
    next_st.arc_n       = ~next_st.arc_seen;
    next_st.life_n      = ~life_sel;
    next_st.code_a      = i_target_sel[0];
    next_st.code_b      = i_target_sel[1];
    next_st.led         = led_mix;
    // Alarm beeps in step with the flashing LEDs; mute silences it
    next_st.alarm = ~st.ctrl[CTRL_MUTE] & blink_phase &
                    (next_st.arc_seen | sp_flash | life_sel);
  end

  // State register; reset gives all lines inactive and LEDs dark
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st             <= '0;
      st.ctrl        <= CTRL_RESET;
      st.output_on_n <= 1'b1;
      st.setpoint_n  <= 1'b1;
      st.arc_n       <= 1'b1;
      st.life_n      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_rdata                 = st.rdata;
  assign o_output_on_n           = st.output_on_n;
  assign o_setpoint_n            = st.setpoint_n;
  assign o_arc_n                 = st.arc_n;
  assign o_target_life_expired_n = st.life_n;
  assign o_target_select_code_a  = st.code_a;
  assign o_target_select_code_b  = st.code_b;
  assign o_status_led            = st.led;
  assign o_alarm                 = st.alarm;
  assign o_arc_shutdown          = st.shutdown;

  // Checks on the decoded outputs
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_trip;
    i_overcurrent;
  endsequence

  sequence s_arc_out;
    !o_arc_n && o_status_led[LED_ARC] && o_arc_shutdown;
  endsequence

  property p_output_line;
    powered |=> !o_output_on_n;
  endproperty
  a_output_line: assert property (p_output_line)
    else $error("output-on line not low while powered");

  property p_output_line_off;
    !powered |=> o_output_on_n;
  endproperty
  a_output_line_off: assert property (p_output_line_off)
    else $error("output-on line low while not powered");

  property p_setpoint_line;
    (i_output_on && i_at_setpoint) |=> !o_setpoint_n;
  endproperty
  a_setpoint_line: assert property (p_setpoint_line)
    else $error("setpoint line not low at setpoint");

  property p_arc;
    s_trip |=> s_arc_out;
  endproperty
  a_arc: assert property (p_arc)
    else $error("arc trip not shown on line, LED and shutdown");

  property p_arc_hold;
    (s_arc_out ##0 i_output_on && !i_overcurrent) |=> !o_arc_n;
  endproperty
  a_arc_hold: assert property (p_arc_hold)
    else $error("arc released while output still on");

  property p_life;
    (i_target_sel == 2'd1) |=> (o_target_life_expired_n == !$past(i_life_expired[1]));
  endproperty
  a_life: assert property (p_life)
    else $error("life line does not follow selected counter");

  // Attempts start only once reset is released; that first edge already loads next_st, not reset values
  property p_code;
    i_rst_b |=> ({o_target_select_code_b, o_target_select_code_a} == $past(i_target_sel));
  endproperty
  a_code: assert property (p_code)
    else $error("target select code wrong");

  property p_ramp_off;
    i_at_setpoint |=> !o_status_led[LED_RAMP];
  endproperty
  a_ramp_off: assert property (p_ramp_off)
    else $error("ramp LED on at setpoint");

  property p_sp_gate;
    !discharge_present_led |=> !o_status_led[LED_SETPOINT];
  endproperty
  a_sp_gate: assert property (p_sp_gate)
    else $error("setpoint LED shown without discharge_present_led");

  property p_sp_flash;
    (sp_flash && blink_phase && !st.ctrl[CTRL_MUTE]) |=>
      (o_status_led[LED_SETPOINT] && o_alarm);
  endproperty
  a_sp_flash: assert property (p_sp_flash)
    else $error("setpoint flash without alarm");

  property p_discharge_present_led;
    i_rst_b |=> (o_status_led[LED_DISCHARGE_PRESENT_LED] ==
      ($past(i_output_on) && ($past(i_out_current) > ($past(i_max_current) >> DISCHARGE_PRESENT_LED_SHIFT))));
  endproperty
  a_discharge_present_led: assert property (p_discharge_present_led)
    else $error("discharge_present_led LED threshold wrong");

  property p_output_led;
    i_rst_b |=> (o_status_led[LED_OUTPUT] == $past(i_output_on));
  endproperty
  a_output_led: assert property (p_output_led)
    else $error("output LED does not follow output on");

  property p_aux_reduced;
    st.ctrl[CTRL_REDUCED] |=> !o_status_led[LED_AUX];
  endproperty
  a_aux_reduced: assert property (p_aux_reduced)
    else $error("auxiliary LED lit on reduced build");

  property p_in_phase;
    (i_ramp_paused && !i_at_setpoint && !blink_phase) |=> !o_status_led[LED_RAMP];
  endproperty
  a_in_phase: assert property (p_in_phase)
    else $error("flash out of phase with blink");

  // Every blink enable pulse marks exactly one phase flip
  property p_blink_tick;
    blink_tick |-> (blink_phase != $past(blink_phase));
  endproperty
  a_blink_tick: assert property (p_blink_tick)
    else $error("blink enable without phase toggle");
endmodule
`default_nettype wire

// ===== shared/sil_pkg.sv
// Shared constants for the status indicator logic
package sil_pkg;
  // Register port
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int          CTRL_REDUCED  = 0;
  localparam int          CTRL_MUTE     = 1;
  // Status word field positions
  localparam int          ST_OUTPUT_N   = 0;
  localparam int          ST_SETPOINT_N = 1;
  localparam int          ST_ARC_N      = 2;
  localparam int          ST_LIFE_N     = 3;
  localparam int          ST_CODE_A     = 4;
  localparam int          ST_CODE_B     = 5;
  localparam int          ST_ALARM      = 6;
  localparam int          ST_SHUTDOWN   = 7;
  localparam int          ST_LED_LSB    = 8;
  // Status indicator LED positions
  localparam int          NUM_LEDS      = 10;
  localparam int          LED_ARC       = 0;
  localparam int          LED_RAMP      = 1;
  localparam int          LED_SETPOINT  = 2;
  localparam int          LED_DISCHARGE_PRESENT_LED    = 3;
  localparam int          LED_OUTPUT    = 4;
  localparam int          LED_LIFE      = 5;
  localparam int          LED_MISC_LSB  = 6;
  localparam int          NUM_MISC      = 4;
  localparam int          LED_AUX       = 9;
  // Target counters and current measurement
  localparam int          NUM_TARGETS   = 3;
  localparam int          CUR_W         = 16;
  localparam int          DISCHARGE_PRESENT_LED_SHIFT  = 10;
  // Blink timing
  localparam int          CLK_MHZ       = 250;
  localparam int          BLINK_HALF_MS = 250;
  localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
endpackage

// ===== rtl/sil_blink.sv
// Shared blink prescaler producing one in-phase flash level
`timescale 1ns/10ps
`default_nettype none
module sil_blink #(
  parameter int HALF_CYC = sil_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  // Blink outputs
  output logic      o_blink_tick,
  output logic      o_blink_phase
);
  import sil_pkg::*;

  localparam int CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
    logic             phase;
  } sil_blink_s;

  sil_blink_s st;
  sil_blink_s next_st;

  // Count one half period, then toggle; tick marks each toggle
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt   = '0;
      next_st.tick  = 1'b1;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_blink_tick  = st.tick;
  assign o_blink_phase = st.phase;
endmodule
`default_nettype wire

// ===== verif/sil_remote_mon.sv
// Remote controller model that reads the user connector status lines
`timescale 1ns/10ps
`default_nettype none
module sil_remote_mon (
  // Status lines from the supply
  input  wire logic       i_output_on_n,
  input  wire logic       i_setpoint_n,
  input  wire logic       i_arc_n,
  input  wire logic       i_target_life_expired_n,
  input  wire logic       i_target_select_code_a,
  input  wire logic       i_target_select_code_b,
  // Decoded view of the controller
  output logic            o_output_seen,
  output logic            o_setpoint_seen,
  output logic            o_arc_seen,
  output logic            o_life_seen,
  output logic      [1:0] o_target_seen
);
  // Overbar lines count as true when low
  assign o_output_seen   = ~i_output_on_n;
  assign o_setpoint_seen = ~i_setpoint_n;
  assign o_arc_seen      = ~i_arc_n;
  assign o_life_seen     = ~i_target_life_expired_n;
  // Select code lines have no overbar, so they are read as they stand
  assign o_target_seen   = {i_target_select_code_b, i_target_select_code_a};
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the status indicator logic
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sil_pkg::*;
  localparam int HALF = 4; // Short blink half period keeps the run brief
  logic                   i_mclk, i_rst_b, i_wr, i_rd;
  logic [ADDR_W-1:0]      i_addr;
  logic [DATA_W-1:0]      i_wdata, o_rdata;
  logic                   contactor, out_on, at_sp, overcur, ramping, paused;
  logic [CUR_W-1:0]       cur, max_cur;
  logic [1:0]             sel, seen_target;
  logic [NUM_TARGETS-1:0] expired;
  logic [NUM_MISC-1:0]    misc_on, misc_flash;
  logic                   output_n, setpoint_n, arc_n, life_n, code_a, code_b;
  logic                   alarm, shutdown, seen_output, seen_setpoint, seen_arc, seen_life;
  logic [NUM_LEDS-1:0]    led;
  int                     miscompares, check_count;

  sil_status #(.BLINK_HALF(HALF)) dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_contactor_closed(contactor),
    .i_output_on(out_on), .i_at_setpoint(at_sp), .i_overcurrent(overcur),
    .i_ramping(ramping), .i_ramp_paused(paused), .i_out_current(cur),
    .i_max_current(max_cur), .i_target_sel(sel), .i_life_expired(expired),
    .i_misc_led_on(misc_on), .i_misc_led_flash(misc_flash), .o_output_on_n(output_n),
    .o_setpoint_n(setpoint_n), .o_arc_n(arc_n), .o_target_life_expired_n(life_n),
    .o_target_select_code_a(code_a), .o_target_select_code_b(code_b),
    .o_status_led(led), .o_alarm(alarm), .o_arc_shutdown(shutdown));

  sil_remote_mon remote (
    .i_output_on_n(output_n), .i_setpoint_n(setpoint_n), .i_arc_n(arc_n),
    .i_target_life_expired_n(life_n), .i_target_select_code_a(code_a),
    .i_target_select_code_b(code_b), .o_output_seen(seen_output),
    .o_setpoint_seen(seen_setpoint), .o_arc_seen(seen_arc), .o_life_seen(seen_life),
    .o_target_seen(seen_target));

  // Clock at 250 MHz
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Outputs follow inputs one edge later; two edges leave margin
  task automatic settle();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // Two full blink periods: count lit cycles, alarm cycles and alarm/LED disagreements
  task automatic flash(input int idx, output int k, output int ka, output int bad);
    k   = 0;
    ka  = 0;
    bad = 0;
    repeat (4 * HALF) begin
      @(posedge i_mclk);
      #1;
      k   += (led[idx] === 1'b1);
      ka  += (alarm === 1'b1);
      bad += (alarm !== led[idx]);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the couple of hundred cycles the tests need
  initial begin
    #100000;
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] d;
    int          k, ka, bad;
    {i_rst_b, i_wr, i_rd, i_addr, i_wdata, contactor, out_on, at_sp} = '0;
    {overcur, ramping, paused, cur, expired, misc_on, misc_flash} = '0;
    sel     = 2'h3;
    max_cur = 16'h4000; // Discharge_present_led threshold is 16'h0010
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    chk(4'hF, {output_n, setpoint_n, arc_n, life_n}, "idle lines");
    chk(32'h0, led, "leds after reset");
    rd(ADDR_CTRL, d);
    chk(CTRL_RESET, d, "ctrl reset");
    // Output on needs the contactor for the line, not for the LED
    @(posedge i_mclk);
    out_on <= 1'b1;
    settle();
    chk(1'b1, output_n, "output line, contactor open");
    chk(1'b1, led[LED_OUTPUT], "output led");
    @(posedge i_mclk);
    contactor <= 1'b1;
    settle();
    chk(1'b0, output_n, "output line");
    chk(1'b1, seen_output, "remote output view");
    // Setpoint at the discharge_present_led threshold, then just above it
    @(posedge i_mclk);
    at_sp <= 1'b1;
    cur   <= 16'h0010;
    settle();
    chk(1'b0, setpoint_n, "setpoint line");
    chk(1'b1, seen_setpoint, "remote setpoint view");
    chk(1'b0, led[LED_DISCHARGE_PRESENT_LED], "discharge_present_led at threshold");
    chk(1'b0, led[LED_SETPOINT], "setpoint led without discharge_present_led");
    @(posedge i_mclk);
    cur <= 16'h0011;
    settle();
    chk(1'b1, led[LED_DISCHARGE_PRESENT_LED], "discharge_present_led above threshold");
    chk(1'b1, led[LED_SETPOINT], "setpoint led lit");
    // Off setpoint: LED flashes with the alarm in step
    @(posedge i_mclk);
    at_sp <= 1'b0;
    settle();
    chk(1'b1, setpoint_n, "setpoint line off target");
    flash(LED_SETPOINT, k, ka, bad);
    chk(2 * HALF, k, "setpoint flash");
    chk(0, bad, "alarm in phase");
    // Ramp lit, paused flashing, out at setpoint
    @(posedge i_mclk);
    ramping <= 1'b1;
    settle();
    chk(1'b1, led[LED_RAMP], "ramp lit");
    @(posedge i_mclk);
    paused <= 1'b1;
    settle();
    flash(LED_RAMP, k, ka, bad);
    chk(2 * HALF, k, "ramp flash");
    @(posedge i_mclk);
    paused <= 1'b0;
    at_sp  <= 1'b1;
    settle();
    chk(1'b0, led[LED_RAMP], "ramp at setpoint");
    @(posedge i_mclk);
    out_on <= 1'b0;
    settle();
    chk(3'h0, {led[LED_SETPOINT], led[LED_DISCHARGE_PRESENT_LED], led[LED_OUTPUT]}, "output off");
    // A one-cycle trip latches until output goes off
    @(posedge i_mclk);
    out_on  <= 1'b1;
    overcur <= 1'b1;
    @(posedge i_mclk);
    overcur <= 1'b0;
    settle();
    chk(1'b0, arc_n, "arc line");
    chk(2'h3, {led[LED_ARC], shutdown}, "arc led and shutdown");
    chk(1'b1, seen_arc, "remote arc view");
    flash(LED_SETPOINT, k, ka, bad);
    chk(2 * HALF, ka, "arc alarm");
    wr(ADDR_CTRL, 32'h1 << CTRL_MUTE);
    settle();
    flash(LED_SETPOINT, k, ka, bad);
    chk(0, ka, "muted alarm");
    @(posedge i_mclk);
    out_on <= 1'b0;
    settle();
    chk(2'h2, {arc_n, shutdown}, "arc cleared");
    // Only the selected counter drives the life line
    @(posedge i_mclk);
    expired <= 3'b010;
    for (int t = 0; t < 4; t++) begin
      @(posedge i_mclk);
      sel <= t[1:0];
      settle();
      chk((t == 1) ? 1'b0 : 1'b1, life_n, "life line");
      chk((t == 1) ? 1'b1 : 1'b0, seen_life, "remote life view");
      chk(t[1:0], {code_b, code_a}, "select code");
      chk(t[1:0], seen_target, "remote select view");
    end
    // Reduced panel drops the auxiliary LED only
    @(posedge i_mclk);
    misc_on <= 4'hF;
    wr(ADDR_CTRL, 32'h1 << CTRL_REDUCED);
    settle();
    chk(4'h7, led[LED_AUX:LED_MISC_LSB], "reduced panel");
    wr(ADDR_CTRL, 32'h0);
    settle();
    chk(1'b1, led[LED_AUX], "standard panel aux");
    rd(ADDR_STATUS, d);
    chk(32'h0003_C03F, d, "status image");
    rd(8'h08, d);
    chk(32'h0, d, "unmapped read");
    // Misc flash requests share the same blink
    @(posedge i_mclk);
    misc_on    <= 4'h0;
    misc_flash <= 4'h1;
    settle();
    flash(LED_MISC_LSB, k, ka, bad);
    chk(2 * HALF, k, "misc flash");
    results();
  end
endmodule
`default_nettype wire
